// ==== hdl/rsp_pkg.sv ====
// Shared constants for the return stack pointer control block.
// Assumes a 32-bit APB register bus and a 21-bit program counter.
package rsp_pkg;
  localparam int RSP_PC_W = 21;
  localparam int RSP_IDX_W = 5;
  localparam int RSP_DEPTH = 31;
  localparam logic [4:0] RSP_IDX_MAX = 5'h1F;
  localparam logic [4:0] RSP_IDX_ZERO = 5'h00;
  // Register byte addresses
  localparam logic [7:0] RSP_OFS_INDEX = 8'h00;
  localparam logic [7:0] RSP_OFS_TOP_LOW = 8'h04;
  localparam logic [7:0] RSP_OFS_TOP_HIGH = 8'h08;
  localparam logic [7:0] RSP_OFS_TOP_UPPER = 8'h0C;
  localparam logic [7:0] RSP_OFS_STATUS = 8'h10;
  // Index register field positions
  localparam int RSP_BIT_FULL = 7;
  localparam int RSP_BIT_UNDERFLOW = 6;
  localparam int RSP_BIT_UNUSED = 5;
  // Status register field positions
  localparam int RSP_BIT_FAULT_EN = 0;
  localparam int RSP_BIT_FAULT_RST = 1;
  localparam logic [7:0] RSP_INDEX_RESET = 8'h00;
  localparam logic [RSP_PC_W-1:0] RSP_PC_STEP = 21'h000002;
  localparam logic [RSP_PC_W-1:0] RSP_PC_ZERO = 21'h000000;
endpackage

// ==== hdl/rsp_stack_ram.sv ====
// Return address storage, one word per nonzero index value.
// Assumes a single clock; read is combinational on the index.
`timescale 1ns/1ns
`default_nettype none
module rsp_stack_ram
  import rsp_pkg::*;
#(
  parameter int DEPTH = RSP_DEPTH,
  parameter int WIDTH = RSP_PC_W
) (
  // Clock
  input wire logic pclk,
  // Write port
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [4:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [1:DEPTH];

  // Index zero has no storage behind it
  always_ff @(posedge pclk) begin
    if (wr_en && wr_idx != RSP_IDX_ZERO) begin
      mem[wr_idx] <= wr_data; // RL21
    end
  end

  assign rd_data = (rd_idx == RSP_IDX_ZERO) ? '0 : mem[rd_idx]; // RL21
endmodule
`default_nettype wire

// ==== hdl/rsp_shadow.sv ====
// One-level shadow of status, working and bank-select registers.
// Assumes the sequencer raises at most one of save and restore.
`timescale 1ns/1ns
`default_nettype none
module rsp_shadow (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic save,
  // Live values
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_in,
  input wire logic [7:0] bank_in,
  // Saved values
  output logic [7:0] status_sv,
  output logic [7:0] working_sv,
  output logic [7:0] bank_sv
);
  // Single level, each save overwrites the last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_sv <= 8'h00;
      working_sv <= 8'h00;
      bank_sv <= 8'h00;
    end else if (save) begin
      status_sv <= status_in; // RL19
      working_sv <= working_in;
      bank_sv <= bank_in;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/rsp_ctrl.sv ====
// Return stack pointer control with APB register access.
// Assumes the core sequencer issues one stack operation per cycle.
//
// What this block does
// RL1 - Five-bit stack index, values 0 to 31
// RL2 - Increment before push, decrement after pop
// RL3 - Any reset zeroes the stack index; here only presetn and the fault reset do, por_n does not
// RL4 - Software reads and writes the index field
// RL5 - Full flag set on thirty-first push
// RL6 - Flags readable, clear-only, cleared by power-on
// RL7 - Fault reset on: store PC plus two, reset
// RL8 - Fault reset off: index sticks at 31
// RL9 - Empty pop returns zero, sets underflow flag
// RL10 - Full or underflow resets device when enabled
// RL11 - Underflow jump to zero is not reset
// RL12 - Push op writes current PC to new top
// RL13 - Pop op only decrements the index
// RL14 - Software writes the top entry bytes
// RL15 - One hidden shadow copy of three registers
// RL16 - Interrupt vectoring loads the shadow copy
// RL17 - Fast interrupt return restores shadow values
// RL18 - Fast call saves, fast return restores
// RL19 - Single shadow level, later save overwrites
// RL20 - Bit 5 ignores writes, reads zero
// RL21 - Thirty-one 21-bit entries, index zero empty
// RL22 - Call increments then stores next PC
// RL23 - Fault reset option sampled once after reset
// RL24 - Writing one leaves flag, zero clears
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rsp_ctrl
  import rsp_pkg::*;
(
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  // Configuration strap
  input wire logic fault_reset_cfg,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core sequencer
  input wire logic push_call,
  input wire logic push_op,
  input wire logic pop_ret,
  input wire logic pop_op,
  input wire logic irq_vector,
  input wire logic fast_save,
  input wire logic fast_restore,
  input wire logic [RSP_PC_W-1:0] pc_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] working_in,
  input wire logic [7:0] bank_in,
  // Core results
  output logic [RSP_PC_W-1:0] pc_ret,
  output logic pc_ret_valid,
  output logic restore_valid,
  output logic [7:0] status_out,
  output logic [7:0] working_out,
  output logic [7:0] bank_out,
  output logic device_reset_req
);
  logic [4:0] stack_index_field;
  logic stack_full_flag;
  logic stack_underflow_flag;
  logic stack_fault_reset_enable;
  logic cfg_taken;
  logic [RSP_PC_W-1:0] top_entry;
  logic [RSP_PC_W-1:0] next_wr_data;
  logic [4:0] next_wr_idx;
  logic next_wr_en;
  logic [4:0] next_index;
  logic next_full_set;
  logic next_unf_set;
  logic do_push;
  logic do_pop;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic idx_wr;
  logic top_wr;
  logic [7:0] index_read;
  logic [31:0] next_rdata;
  logic [7:0] status_sv;
  logic [7:0] working_sv;
  logic [7:0] bank_sv;
  logic shadow_save;

  assign do_push = push_call || push_op;
  assign do_pop = pop_ret || pop_op;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign addr_ok = (paddr == RSP_OFS_INDEX) || (paddr == RSP_OFS_TOP_LOW) ||
    (paddr == RSP_OFS_TOP_HIGH) || (paddr == RSP_OFS_TOP_UPPER) ||
    (paddr == RSP_OFS_STATUS);
  assign idx_wr = apb_wr && (paddr == RSP_OFS_INDEX);
  assign top_wr = apb_wr && ((paddr == RSP_OFS_TOP_LOW) ||
    (paddr == RSP_OFS_TOP_HIGH) || (paddr == RSP_OFS_TOP_UPPER));
  assign shadow_save = irq_vector || (push_call && fast_save); // RL16 RL18

  // Strap sampled once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_taken <= 1'b0;
      stack_fault_reset_enable <= 1'b1;
    end else if (!cfg_taken) begin
      cfg_taken <= 1'b1;
      stack_fault_reset_enable <= fault_reset_cfg; // RL23
    end
  end

  // Push and pop sequencing
  always_comb begin
    next_index = stack_index_field;
    next_wr_en = 1'b0;
    next_wr_idx = stack_index_field;
    next_wr_data = pc_in;
    next_full_set = 1'b0;
    next_unf_set = 1'b0;
    if (do_push) begin
      if (stack_index_field == RSP_IDX_MAX) begin
        next_index = RSP_IDX_MAX; // RL8
        next_full_set = 1'b1;
      end else begin
        next_index = stack_index_field + 5'h01; // RL2 RL22 RL12
        next_wr_en = 1'b1;
        next_wr_idx = next_index;
        if (next_index == RSP_IDX_MAX) begin
          next_full_set = 1'b1; // RL5
          if (stack_fault_reset_enable) begin
            next_wr_data = pc_in + RSP_PC_STEP; // RL7
          end
        end
      end
    end else if (do_pop) begin
      if (stack_index_field == RSP_IDX_ZERO) begin
        next_unf_set = 1'b1; // RL9
      end else begin
        next_index = stack_index_field - 5'h01; // RL2 RL13
      end
    end else if (top_wr) begin
      next_wr_en = 1'b1; // RL14
      next_wr_data = top_entry;
      unique case (paddr)
        RSP_OFS_TOP_LOW: next_wr_data[7:0] = pwdata[7:0];
        RSP_OFS_TOP_HIGH: next_wr_data[15:8] = pwdata[7:0];
        default: next_wr_data[20:16] = pwdata[4:0];
      endcase
    end else if (idx_wr) begin
      next_index = pwdata[4:0]; // RL4 RL20
    end
  end

  // Stack index, cleared by presetn or the fault reset request, not by por_n
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_index_field <= RSP_IDX_ZERO; // RL3 RL1
    end else if (device_reset_req) begin
      stack_index_field <= RSP_IDX_ZERO; // RL7
    end else begin
      stack_index_field <= next_index;
    end
  end

  // Flags survive ordinary reset, set beats clear
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      stack_full_flag <= 1'b0; // RL6
      stack_underflow_flag <= 1'b0;
    end else begin
      if (next_full_set) begin
        stack_full_flag <= 1'b1;
      end else if (idx_wr && !pwdata[RSP_BIT_FULL]) begin
        stack_full_flag <= 1'b0; // RL24
      end
      if (next_unf_set) begin
        stack_underflow_flag <= 1'b1;
      end else if (idx_wr && !pwdata[RSP_BIT_UNDERFLOW]) begin
        stack_underflow_flag <= 1'b0; // RL24
      end
    end
  end

  // Fault reset request raised on the same edge that sets a flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= stack_fault_reset_enable && !device_reset_req &&
        (next_full_set || next_unf_set); // RL10
    end
  end

  rsp_stack_ram #(
    .DEPTH(RSP_DEPTH),
    .WIDTH(RSP_PC_W)
  ) u_ram (
    .pclk(pclk),
    .wr_en(next_wr_en),
    .wr_idx(next_wr_idx),
    .wr_data(next_wr_data),
    .rd_idx(stack_index_field),
    .rd_data(top_entry)
  );

  rsp_shadow u_shadow (
    .pclk(pclk),
    .presetn(presetn),
    .save(shadow_save),
    .status_in(status_in),
    .working_in(working_in),
    .bank_in(bank_in),
    .status_sv(status_sv),
    .working_sv(working_sv),
    .bank_sv(bank_sv)
  ); // RL15

  // Return value and shadow restore to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ret <= RSP_PC_ZERO;
      pc_ret_valid <= 1'b0;
    end else begin
      pc_ret_valid <= pop_ret && !do_push;
      if (pop_ret && !do_push) begin
        pc_ret <= top_entry; // RL9 RL11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_valid <= 1'b0;
      status_out <= 8'h00;
      working_out <= 8'h00;
      bank_out <= 8'h00;
    end else begin
      restore_valid <= pop_ret && fast_restore && !do_push; // RL17 RL18
      if (pop_ret && fast_restore && !do_push) begin
        status_out <= status_sv;
        working_out <= working_sv;
        bank_out <= bank_sv;
      end
    end
  end

  // APB read data, captured in setup cycle
  assign index_read = {stack_full_flag, stack_underflow_flag, 1'b0,
    stack_index_field}; // RL6 RL20

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (paddr)
      RSP_OFS_INDEX: next_rdata[7:0] = index_read;
      RSP_OFS_TOP_LOW: next_rdata[7:0] = top_entry[7:0];
      RSP_OFS_TOP_HIGH: next_rdata[7:0] = top_entry[15:8];
      RSP_OFS_TOP_UPPER: next_rdata[4:0] = top_entry[20:16];
      RSP_OFS_STATUS: begin
        next_rdata[RSP_BIT_FAULT_EN] = stack_fault_reset_enable;
        next_rdata[RSP_BIT_FAULT_RST] = device_reset_req;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (apb_rd) begin
        prdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/rsp_core_model.sv ====
// Core sequencer model: one stack request per rising edge.
// Assumes callers enter op and idle just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module rsp_core_model
  import rsp_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Stack requests
  output logic push_call,
  output logic push_op,
  output logic pop_ret,
  output logic pop_op,
  output logic irq_vector,
  output logic fast_save,
  output logic fast_restore,
  // Live core state
  output logic [RSP_PC_W-1:0] pc_in,
  output logic [7:0] status_in,
  output logic [7:0] working_in,
  output logic [7:0] bank_in
);
  initial begin
    {push_call, push_op, pop_ret, pop_op, irq_vector} = 5'h00;
    {fast_save, fast_restore, pc_in, status_in, working_in, bank_in} = '0;
  end
  // Kinds: 0 call, 1 push op, 2 return, 3 pop op, 4 vector
  task automatic op(input int k, input logic [RSP_PC_W-1:0] pc,
    input logic fx, input logic [23:0] sh);
    {push_call, push_op, pop_ret, pop_op, irq_vector} <= 5'h10 >> k;
    fast_save <= fx && k == 0;
    fast_restore <= fx && k == 2;
    {pc_in, status_in, working_in, bank_in} <= {pc, sh};
    @(posedge pclk);
  endtask
  // Released data lines stop showing the last value
  task automatic idle();
    {push_call, push_op, pop_ret, pop_op, irq_vector} <= 5'h00;
    {fast_save, fast_restore} <= 2'h0;
    pc_in <= ~pc_in;
    {status_in, working_in, bank_in} <= ~{status_in, working_in, bank_in};
  endtask
endmodule
`default_nettype wire

// ==== dv/rsp_ctrl_checker.sv ====
// Assertion checker for the return stack control block.
// Bound into rsp_ctrl; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module rsp_ctrl_checker
  import rsp_pkg::*;
(
  // Clock, reset, strap
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fault_reset_cfg,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Core
  input wire logic pop_ret,
  input wire logic irq_vector,
  input wire logic fast_restore,
  input wire logic [7:0] status_in,
  input wire logic pc_ret_valid,
  input wire logic restore_valid,
  input wire logic [7:0] status_out,
  input wire logic device_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_ret; pop_ret |=> pc_ret_valid; endproperty
  a_ret: assert property (p_ret) else $error("no return");
  property p_noret; !pop_ret |=> !pc_ret_valid; endproperty
  a_noret: assert property (p_noret) else $error("stray return");
  property p_rest; pop_ret && fast_restore |=> restore_valid; endproperty
  a_rest: assert property (p_rest) else $error("no restore");
  property p_norest; !(pop_ret && fast_restore) |=> !restore_valid;
  endproperty
  a_norest: assert property (p_norest) else $error("stray restore");
  property p_shadow; irq_vector ##1 (pop_ret && fast_restore)
    |=> status_out == $past(status_in, 2); endproperty
  a_shadow: assert property (p_shadow) else $error("bad shadow");
  property p_bit5; psel && penable && pready && !pwrite
    && paddr == RSP_OFS_INDEX |-> prdata[31:8] == 24'h0 && !prdata[5];
  endproperty
  a_bit5: assert property (p_bit5) else $error("bad index read");
  property p_noreq; !fault_reset_cfg |-> !device_reset_req; endproperty
  a_noreq: assert property (p_noreq) else $error("stray reset");
  c_req: cover property (device_reset_req);
  c_rest: cover property (restore_valid);
  c_err: cover property (psel && penable && paddr > RSP_OFS_STATUS);
endmodule
bind rsp_ctrl rsp_ctrl_checker chk (.*);
`default_nettype wire

// ==== dv/return_stack_pointer_ctrl_test.sv ====
// Self-checking bench for the return stack control block.
// Drives APB and the core model; compares with a reference model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((e) !== (a)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module return_stack_pointer_ctrl_test
  import rsp_pkg::*;
();
  logic pclk = 0, presetn = 0, por_n = 0, fault_reset_cfg = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pc_ret_valid, restore_valid, device_reset_req;
  logic push_call, push_op, pop_ret, pop_op, irq_vector, fast_save;
  logic fast_restore;
  logic [RSP_PC_W-1:0] pc_in, pc_ret, v;
  logic [7:0] status_in, working_in, bank_in, status_out, working_out;
  logic [7:0] bank_out;
  logic [RSP_PC_W-1:0] stk [32];
  logic [1:0] fl = 0;
  logic [23:0] shd;
  int fails = 0, checks_done = 0, idx = 0, n;
  always #50 pclk = ~pclk;
  rsp_ctrl uut (.*);
  rsp_core_model core (.*);
  task automatic finish_test();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 9);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    if (k >= 9) begin
      fails++;
      finish_test();
    end
    @(posedge pclk);
  endtask
  task automatic chk_idx();
    apb(1'h0, RSP_OFS_INDEX, 32'h0);
    `CHK("index", {24'h0, fl, 1'h0, 5'(idx)}, rd)
  endtask
  task automatic push(input int k);
    v = RSP_PC_W'($urandom) << 1;
    core.op(k, v, 1'h0, 24'($urandom));
    if (idx < RSP_DEPTH) begin
      idx++;
      stk[idx] = v;
      if (idx == RSP_DEPTH && fault_reset_cfg)
        stk[idx] = v + RSP_PC_STEP;
    end
    if (idx == RSP_DEPTH) fl[1] = 1'h1;
  endtask
  task automatic pop(input int k);
    core.op(k, v, 1'h0, 24'($urandom));
    core.idle();
    v = idx ? stk[idx] : RSP_PC_ZERO;
    @(posedge pclk);
    if (k == 2) `CHK("pc_ret", {1'h1, v}, {pc_ret_valid, pc_ret})
    if (idx == 0) fl[0] = 1'h1;
    else idx--;
  endtask
  initial begin
    void'($urandom(14));
    repeat (10) @(posedge pclk);
    {presetn, por_n} <= 2'h3;
    @(posedge pclk);
    chk_idx();
    repeat (33) push($urandom % 2);
    core.idle();
    chk_idx();
    v = RSP_PC_W'($urandom);
    for (int b = 0; b < 3; b++)
      apb(1'h1, RSP_OFS_TOP_LOW + 8'(4 * b), {24'h0, 8'(v >> 8 * b)});
    stk[idx] = v;
    apb(1'h0, RSP_OFS_TOP_UPPER, 32'h0);
    `CHK("top", {27'h0, v[20:16]}, rd)
    pop(2);
    repeat (31) pop(idx ? 2 + $urandom % 2 : 2);
    chk_idx();
    apb(1'h1, RSP_OFS_INDEX, 32'hFFFFFFFF);
    idx = 31;
    chk_idx();
    apb(1'h1, RSP_OFS_INDEX, 32'h07);
    fl = 2'h0;
    idx = 7;
    chk_idx();
    pop(2);
    shd = 24'($urandom);
    core.op(4, v, 1'h0, shd);
    core.op(2, v, 1'h1, ~shd);
    core.op(0, v, 1'h1, ~shd);
    `CHK("restore", {1'h1, shd}, {restore_valid, status_out, working_out, bank_out})
    core.op(4, v, 1'h0, shd);
    core.op(2, v, 1'h0, ~shd);
    core.op(2, v, 1'h1, ~shd);
    `CHK("plain return", 1'h0, restore_valid)
    core.idle();
    @(posedge pclk);
    `CHK("restore", {1'h1, shd}, {restore_valid, status_out, working_out, bank_out})
    apb(1'h0, 8'h20, 32'h0);
    `CHK("unmapped", {1'h1, 32'h0}, {err, rd})
    {presetn, fault_reset_cfg} <= 2'h1;
    @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    idx = 0;
    chk_idx();
    repeat (31) push(0);
    core.idle();
    n = 0;
    while (device_reset_req !== 1'h1 && n < 5) begin
      @(posedge pclk);
      n++;
    end
    `CHK("reset_req", 1'h1, device_reset_req)
    if (n >= 5) finish_test();
    repeat (3) @(posedge pclk);
    idx = 0;
    chk_idx();
    apb(1'h1, RSP_OFS_INDEX, 32'hDF);
    apb(1'h0, RSP_OFS_TOP_LOW, 32'h0);
    `CHK("top plus two", {24'h0, stk[31][7:0]}, rd)
    finish_test();
  end
endmodule
`default_nettype wire
